/* src/pfs_regs.svh */
// register map, field positions, thresholds and timing of the supervisor
`ifndef PFS_REGS_SVH
`define PFS_REGS_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define PFS_CTRL_OFS 12'h000
`define PFS_CFG_OFS 12'h004
`define PFS_STAT_OFS 12'h008
`define PFS_CTRL_RST 32'h0000_0000
`define PFS_CFG_RST 32'h0000_002A
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PFS_CTRL_EN 0
`define PFS_CTRL_CLR 1
`define PFS_CFG_OC_LSB 0
`define PFS_CFG_OV_LSB 4
`define PFS_CFG_UV_LSB 6
`define PFS_CFG_PG 8
`define PFS_CFG_LATCH_LSB 9
`define PFS_CFG_TRK_EN 14
`define PFS_CFG_W 15
// ----------------------------------------------------------------------
// thresholds, percent of rated or set values, millivolts, degrees C
// ----------------------------------------------------------------------
`define PFS_OC_BASE 8'h3C
`define PFS_OC_STEP 8'h0C
`define PFS_OC_MAXSTEP 4'hA
`define PFS_OV_BASE 8'h6E
`define PFS_OV_STEP 8'h0A
`define PFS_OV_MAXSTEP 2'h2
`define PFS_OV_FLOOR_MV 17'h003E8
`define PFS_UV_BASE 8'h4B
`define PFS_UV_STEP 8'h05
`define PFS_UV_MAXSTEP 2'h2
`define PFS_PG_LO_BASE 8'h5A
`define PFS_PG_LO_STEP 8'h05
`define PFS_PG_HI 8'h6E
`define PFS_PCT_DIV 24'h000064
`define PFS_TRK_MV 17'h000FA
`define PFS_OT_OFF_C 8'h82
`define PFS_OT_ON_C 8'h78
`define PFS_WARN_C 8'h78
`define PFS_WARN_HYST_C 8'h03
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PFS_CLK_NS 25
`define PFS_DLY_NS 6000
`define PFS_RETRY_NS 130000000
`endif

/* src/pfs_pkg.sv */
// types shared by the fault supervisor
package pfs_pkg;
  // gray along off, on, retry wait, latched
  typedef enum logic [1:0] {
    PFS_OFF = 2'h0,
    PFS_ON = 2'h1,
    PFS_RETRY = 2'h3,
    PFS_LATCHED = 2'h2
  } pfs_state_e;
  // index of each filtered condition
  typedef enum int {
    PFS_C_OC = 0, PFS_C_OV = 1, PFS_C_UV = 2, PFS_C_OT = 3,
    PFS_C_TRK = 4, PFS_C_WARN = 5, PFS_C_PG = 6
  } pfs_cond_e;
  localparam int PFS_NCOND = 7;
  localparam int PFS_NFAULT = 5;
endpackage : pfs_pkg

/* src/pfs_supervisor.sv */
// fault supervisor for a step-down power stage, with apb registers
// Contract
// R1 - oc, ov, uv faults retry every 130 ms by default; each can latch
// R2 - overcurrent trip 60 to 180 percent rated, 11 steps, default 180
// R3 - overvoltage trip 110 to 130 percent set, 10 percent steps, default 130
// R4 - overvoltage trip level never below 1.0 V
// R5 - undervoltage trip 75 to 85 percent set, 5 percent steps, default 75
// R6 - turn-off command about 6 us after any threshold crossing
// R7 - overtemperature off at 130 C, turn-on allowed again at 120 C
// R8 - tracking off by default; trips beyond 250 mV only while ramping up
// R9 - overtemperature warning at 120 C, 3 C hysteresis, status flag
// R10 - warning flag follows threshold crossing by about 6 us
// R11 - power good high inside window 90..95 to 110 percent, else low
// R12 - power good changes about 6 us after a window crossing
// R13 - latched fault holds stage off until disable or clear command
// R14 - after reset all types and thresholds take their defaults
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/100ps
`include "pfs_regs.svh"
module pfs_supervisor
  import pfs_pkg::*;
#(
  parameter int RETRY_CYC = `PFS_RETRY_NS / `PFS_CLK_NS
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] iout_ma,
  input wire logic [15:0] irated_ma,
  input wire logic [15:0] vout_mv,
  input wire logic [15:0] vset_mv,
  input wire logic [15:0] vtrack_mv,
  input wire logic ramp_up,
  input wire logic [7:0] temp_c,
  output logic stage_off_cmd,
  output logic power_good_out,
  output logic ot_warning
);
  localparam int DLY_CYC = `PFS_DLY_NS / `PFS_CLK_NS;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [16:0] pct_of(input logic [15:0] v,
                                         input logic [7:0] p);
    logic [23:0] prod;
    prod = 24'(v) * 24'(p);
    return 17'(prod / `PFS_PCT_DIV);
  endfunction : pct_of

  function automatic logic [7:0] step_pct(input logic [7:0] base,
                                          input logic [7:0] step,
                                          input logic [3:0] n);
    return 8'(base + step * 8'(n));
  endfunction : step_pct

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic en_r;
  logic clr_r;
  logic [`PFS_CFG_W-1:0] cfg_r;
  logic [PFS_NFAULT-1:0] cause_r;
  logic [PFS_NFAULT-1:0] cause_nxt;
  pfs_state_e st_r;
  logic [22:0] retry_r;
  logic [PFS_NCOND-1:0] raw;
  logic [PFS_NCOND-1:0] filt_r;
  logic [7:0] cnt_r [PFS_NCOND];
  logic wr_en;
  logic [31:0] rd_val;
  logic rd_ok;

  assign wr_en = psel & penable & pready & pwrite;

  always_comb begin
    rd_ok = 1'b1;
    unique case (paddr)
      `PFS_CTRL_OFS: rd_val = 32'(en_r);
      `PFS_CFG_OFS: rd_val = 32'(cfg_r);
      `PFS_STAT_OFS: rd_val = {20'h0_0000, 1'b0, stage_off_cmd,
                               power_good_out, filt_r[PFS_C_WARN],
                               st_r, 1'b0, cause_r};
      default: begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // answer is set up during the setup cycle, so access ends at once
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      prdata <= (psel & ~penable & ~pwrite) ? rd_val : 32'h0000_0000;
      pslverr <= psel & ~penable & ~rd_ok;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      en_r <= 1'b0;
      clr_r <= 1'b0;
      cfg_r <= `PFS_CFG_W'(`PFS_CFG_RST); // R14
    end else begin
      clr_r <= wr_en && paddr == `PFS_CTRL_OFS && pwdata[`PFS_CTRL_CLR];
      if (wr_en && paddr == `PFS_CTRL_OFS)
        en_r <= pwdata[`PFS_CTRL_EN];
      if (wr_en && paddr == `PFS_CFG_OFS)
        cfg_r <= pwdata[`PFS_CFG_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // thresholds
  // ----------------------------------------------------------------------
  logic [3:0] oc_n;
  logic [1:0] ov_n;
  logic [1:0] uv_n;
  logic [16:0] oc_thr;
  logic [16:0] ov_pct_thr;
  logic [16:0] ov_thr;
  logic [16:0] uv_thr;
  logic [16:0] pg_lo;
  logic [16:0] pg_hi;
  logic [16:0] trk_dev;
  logic [4:0] latch_sel;

  // out of range steps saturate at the top setting
  assign oc_n = (cfg_r[`PFS_CFG_OC_LSB +: 4] > `PFS_OC_MAXSTEP) ?
                `PFS_OC_MAXSTEP : cfg_r[`PFS_CFG_OC_LSB +: 4];
  assign ov_n = (cfg_r[`PFS_CFG_OV_LSB +: 2] > `PFS_OV_MAXSTEP) ?
                `PFS_OV_MAXSTEP : cfg_r[`PFS_CFG_OV_LSB +: 2];
  assign uv_n = (cfg_r[`PFS_CFG_UV_LSB +: 2] > `PFS_UV_MAXSTEP) ?
                `PFS_UV_MAXSTEP : cfg_r[`PFS_CFG_UV_LSB +: 2];
  assign oc_thr = pct_of(irated_ma,
    step_pct(`PFS_OC_BASE, `PFS_OC_STEP, oc_n)); // R2
  assign ov_pct_thr = pct_of(vset_mv,
    step_pct(`PFS_OV_BASE, `PFS_OV_STEP, {2'h0, ov_n})); // R3
  assign ov_thr = (ov_pct_thr < `PFS_OV_FLOOR_MV) ? `PFS_OV_FLOOR_MV :
                  ov_pct_thr; // R4
  assign uv_thr = pct_of(vset_mv,
    step_pct(`PFS_UV_BASE, `PFS_UV_STEP, {2'h0, uv_n})); // R5
  assign pg_lo = pct_of(vset_mv, step_pct(`PFS_PG_LO_BASE,
    `PFS_PG_LO_STEP, {3'h0, cfg_r[`PFS_CFG_PG]})); // R11
  assign pg_hi = pct_of(vset_mv, `PFS_PG_HI); // R11
  assign trk_dev = (vout_mv > vtrack_mv) ? 17'(vout_mv - vtrack_mv) :
                   17'(vtrack_mv - vout_mv);
  assign latch_sel = cfg_r[`PFS_CFG_LATCH_LSB +: 5];

  // ----------------------------------------------------------------------
  // raw conditions and 6 us persistence filters
  // ----------------------------------------------------------------------
  always_comb begin
    raw[PFS_C_OC] = 17'(iout_ma) > oc_thr;
    raw[PFS_C_OV] = 17'(vout_mv) > ov_thr;
    raw[PFS_C_UV] = (st_r == PFS_ON) && !ramp_up &&
                    17'(vout_mv) < uv_thr;
    raw[PFS_C_OT] = filt_r[PFS_C_OT] ? temp_c > `PFS_OT_ON_C :
                    temp_c >= `PFS_OT_OFF_C; // R7
    raw[PFS_C_TRK] = cfg_r[`PFS_CFG_TRK_EN] && ramp_up &&
                     trk_dev > `PFS_TRK_MV; // R8
    raw[PFS_C_WARN] = filt_r[PFS_C_WARN] ?
      temp_c > 8'(`PFS_WARN_C - `PFS_WARN_HYST_C) :
      temp_c >= `PFS_WARN_C; // R9
    raw[PFS_C_PG] = 17'(vout_mv) >= pg_lo &&
                    17'(vout_mv) <= pg_hi; // R11
  end

  // a state flips only after raw differs for DLY_CYC cycles in a row
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      filt_r <= '0;
      for (int i = 0; i < PFS_NCOND; i++)
        cnt_r[i] <= 8'h00;
    end else begin
      for (int i = 0; i < PFS_NCOND; i++) begin
        if (raw[i] == filt_r[i]) begin
          cnt_r[i] <= 8'h00;
        end else if (cnt_r[i] == 8'(DLY_CYC - 1)) begin
          cnt_r[i] <= 8'h00;
          filt_r[i] <= raw[i]; // R6 R10 R12
        end else begin
          cnt_r[i] <= cnt_r[i] + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // shutdown, retry and latch control
  // ----------------------------------------------------------------------
  logic [PFS_NFAULT-1:0] trip;
  logic retry_done;

  assign trip = filt_r[PFS_NFAULT-1:0];
  assign retry_done = retry_r == 23'(RETRY_CYC - 1);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r <= PFS_OFF;
    end else if (!en_r) begin
      st_r <= PFS_OFF; // R13
    end else begin
      unique case (st_r)
        PFS_OFF:
          if (!filt_r[PFS_C_OT])
            st_r <= PFS_ON; // R7
        PFS_ON:
          if (|(trip & latch_sel))
            st_r <= PFS_LATCHED; // R1
          else if (|trip)
            st_r <= PFS_RETRY; // R1
        PFS_RETRY:
          if (retry_done && !filt_r[PFS_C_OT])
            st_r <= PFS_ON; // R1 R7
        PFS_LATCHED:
          if (clr_r)
            st_r <= PFS_OFF; // R13
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      retry_r <= 23'h00_0000;
    else if (st_r != PFS_RETRY || retry_done)
      retry_r <= 23'h00_0000;
    else
      retry_r <= retry_r + 23'h00_0001; // R1
  end

  // new fault causes win over a clear in the same cycle
  always_comb begin
    cause_nxt = clr_r ? '0 : cause_r;
    if (st_r == PFS_ON)
      cause_nxt = cause_nxt | trip;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      cause_r <= '0;
    else
      cause_r <= cause_nxt;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stage_off_cmd <= 1'b1;
      power_good_out <= 1'b0;
      ot_warning <= 1'b0;
    end else begin
      // trip is acted on here as well, so the stage drops with the state change
      stage_off_cmd <= !(st_r == PFS_ON && trip == '0) &&
                       !(st_r == PFS_OFF && en_r &&
                         !filt_r[PFS_C_OT]) &&
                       !(st_r == PFS_RETRY && retry_done && en_r &&
                         !filt_r[PFS_C_OT]); // R6
      power_good_out <= filt_r[PFS_C_PG]; // R12
      ot_warning <= filt_r[PFS_C_WARN]; // R9 R10
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_trip_seen;
    st_r == PFS_ON && trip != '0;
  endsequence

  sequence s_off_held;
    stage_off_cmd [*2];
  endsequence

  ov_floor_a: assert property (ov_thr >= `PFS_OV_FLOOR_MV) // R4
    else $error("overvoltage trip level below floor");

  trip_off_a: assert property (s_trip_seen |=> s_off_held) // R6
    else $error("turn-off not issued after trip");

  filt_delay_a: assert property ($rose(filt_r[PFS_C_OC]) |->
    $past(cnt_r[PFS_C_OC]) == 8'(DLY_CYC - 1)) // R6
    else $error("overcurrent state changed before delay");

  retry_wait_a: assert property (st_r == PFS_RETRY && !retry_done
    |=> st_r != PFS_ON) // R1
    else $error("restart before retry period ended");

  ot_hold_a: assert property (filt_r[PFS_C_OT] && st_r != PFS_ON
    |=> st_r != PFS_ON) // R7
    else $error("turn-on while overtemperature active");

  trk_gate_a: assert property ($rose(filt_r[PFS_C_TRK]) |->
    $past(cfg_r[`PFS_CFG_TRK_EN]) && $past(ramp_up)) // R8
    else $error("tracking trip outside ramp or disabled");

  warn_flag_a: assert property ($changed(filt_r[PFS_C_WARN])
    |=> ot_warning == $past(filt_r[PFS_C_WARN]) &&
        $past(cnt_r[PFS_C_WARN], 2) == 8'(DLY_CYC - 1)) // R9 R10
    else $error("warning flag out of step");

  pg_follow_a: assert property ($changed(filt_r[PFS_C_PG])
    |=> power_good_out == $past(filt_r[PFS_C_PG]) &&
        $past(cnt_r[PFS_C_PG], 2) == 8'(DLY_CYC - 1)) // R11 R12
    else $error("power good not following window");

  latch_hold_a: assert property (st_r == PFS_LATCHED && en_r && !clr_r
    |=> st_r == PFS_LATCHED ##1 stage_off_cmd) // R13
    else $error("latched fault released without clear");

  uv_retry_a: assert property (st_r == PFS_ON && trip[PFS_C_UV] &&
    !(|(trip & latch_sel)) && en_r |=> st_r == PFS_RETRY) // R1 R5
    else $error("non-latching fault did not enter retry");

endmodule : pfs_supervisor

/* sim/pfs_stage_model.sv */
// behavioural power stage and measurement front end
`timescale 1ns/100ps
module pfs_stage_model (
  input wire logic mclk,
  input wire logic stage_off_cmd,
  input wire logic [15:0] v_tgt,
  input wire logic [15:0] i_tgt,
  input wire logic [7:0] t_tgt,
  output logic [15:0] vout_mv,
  output logic [15:0] iout_ma,
  output logic [7:0] temp_c
);
  initial begin
    vout_mv = 16'h0000;
    iout_ma = 16'h0000;
    temp_c = 8'h19;
  end
  // a stage held off collapses its output and carries no current
  always @(posedge mclk) begin
    vout_mv <= stage_off_cmd ? 16'h0000 : v_tgt;
    iout_ma <= stage_off_cmd ? 16'h0000 : i_tgt;
    temp_c <= t_tgt;
  end
endmodule : pfs_stage_model

/* sim/testbench.sv */
// self-checking bench for the fault supervisor
`timescale 1ns/100ps
`include "pfs_regs.svh"
module testbench;
  localparam int RCYC = 300;
  localparam int DLO = 225;
  localparam int DHI = 255;
  logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, stage_off_cmd, power_good_out, ot_warning;
  logic [15:0] iout_ma, vout_mv;
  logic [15:0] irated_ma = 16'h03E8, vset_mv = 16'h03E8;
  logic [15:0] v_tgt = 16'h03E8, i_tgt = 16'h0000;
  logic [7:0] t_tgt = 8'h19, temp_c;
  logic ramp_up = 1'b0;
  logic [15:0] vtrack_mv = 16'h03E8;
  int error_cnt = 0, tests_run = 0;
  logic [31:0] exp_q[$], obs_q[$];
  always #12.5 mclk = ~mclk;
  pfs_supervisor #(.RETRY_CYC(RCYC)) i_dut (.mclk(mclk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .iout_ma(iout_ma), .irated_ma(irated_ma), .vout_mv(vout_mv),
    .vset_mv(vset_mv), .vtrack_mv(vtrack_mv), .ramp_up(ramp_up),
    .temp_c(temp_c), .stage_off_cmd(stage_off_cmd),
    .power_good_out(power_good_out), .ot_warning(ot_warning));
  pfs_stage_model i_stage (.mclk(mclk), .stage_off_cmd(stage_off_cmd),
    .v_tgt(v_tgt), .i_tgt(i_tgt), .t_tgt(t_tgt), .vout_mv(vout_mv),
    .iout_ma(iout_ma), .temp_c(temp_c));
  // ----------------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------------
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task note(input logic [31:0] got, input logic [31:0] exp);
    obs_q.push_back(got);
    exp_q.push_back(exp);
  endtask : note
  always @(negedge mclk) begin
    while (obs_q.size() > 0) check(obs_q.pop_front(), exp_q.pop_front());
  end
  task stop_test;
    repeat (2) @(posedge mclk);
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  // ----------------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------------
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) begin
      $display("ERROR %0t: bus transfer timed out", $time);
      error_cnt++;
      stop_test;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  // waits for an output level; 0 stage off, 1 power good, 2 warning
  task wait_out(input int sel, input logic val, input int lim, output int n);
    logic s;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      s = sel == 0 ? stage_off_cmd : sel == 1 ? power_good_out : ot_warning;
    end while (s !== val && n < lim);
    if (s !== val) begin
      error_cnt++;
      $display("ERROR %0t: output %0d never settled", $time, sel);
      stop_test;
    end
  endtask : wait_out
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic er;
    int n;
    void'($urandom(29));
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    apb(1'b0, `PFS_CFG_OFS, 32'h0, rd, er);
    note(rd, `PFS_CFG_RST);
    apb(1'b0, `PFS_CTRL_OFS, 32'h0, rd, er);
    note(rd, `PFS_CTRL_RST);
    apb(1'b0, 12'h00C, 32'h0, rd, er);
    note({er, rd[30:0]}, 32'h8000_0000);
    $display("defaults done");
    i_tgt <= 16'($urandom_range(1700, 200));
    apb(1'b1, `PFS_CTRL_OFS, 32'h1, rd, er);
    wait_out(0, 1'b0, 5, n);
    wait_out(1, 1'b1, 400, n);
    note(32'(n inside {[DLO:DHI]}), 32'h1);
    v_tgt <= 16'h0370;
    wait_out(1, 1'b0, 400, n);
    note(32'(n inside {[DLO:DHI]}), 32'h1);
    v_tgt <= 16'h03E8;
    $display("power good done");
    i_tgt <= 16'h06FE;
    repeat (300) @(posedge mclk);
    note(32'(stage_off_cmd), 32'h0);
    i_tgt <= 16'h0712;
    wait_out(0, 1'b1, 400, n);
    note(32'(n inside {[DLO:DHI]}), 32'h1);
    i_tgt <= 16'h01F4;
    wait_out(0, 1'b0, 2000, n);
    note(32'(n >= RCYC), 32'h1);
    apb(1'b0, `PFS_STAT_OFS, 32'h0, rd, er);
    note(32'(rd[0]), 32'h1);
    $display("retry done");
    apb(1'b1, `PFS_CFG_OFS, 32'h0000_022A, rd, er);
    i_tgt <= 16'h0712;
    wait_out(0, 1'b1, 400, n);
    i_tgt <= 16'h01F4;
    repeat (4 * RCYC + 300) @(posedge mclk);
    note(32'(stage_off_cmd), 32'h1);
    apb(1'b0, `PFS_STAT_OFS, 32'h0, rd, er);
    note(32'(rd[7:6]), 32'h2);
    apb(1'b1, `PFS_CTRL_OFS, 32'h3, rd, er);
    wait_out(0, 1'b0, 400, n);
    apb(1'b1, `PFS_CFG_OFS, `PFS_CFG_RST, rd, er);
    $display("latch done");
    v_tgt <= 16'h03B6;
    vset_mv <= 16'h01F4;
    repeat (300) @(posedge mclk);
    note(32'(stage_off_cmd), 32'h0);
    v_tgt <= 16'h041A;
    wait_out(0, 1'b1, 400, n);
    note(32'(n inside {[DLO:DHI]}), 32'h1);
    v_tgt <= 16'h03E8;
    vset_mv <= 16'h03E8;
    wait_out(0, 1'b0, 2000, n);
    $display("overvoltage done");
    v_tgt <= 16'h02F8;
    repeat (300) @(posedge mclk);
    note(32'(stage_off_cmd), 32'h0);
    v_tgt <= 16'h02E4;
    wait_out(0, 1'b1, 400, n);
    note(32'(n inside {[DLO:DHI]}), 32'h1);
    v_tgt <= 16'h03E8;
    wait_out(0, 1'b0, 2000, n);
    apb(1'b0, `PFS_STAT_OFS, 32'h0, rd, er);
    note(32'(rd[2]), 32'h1);
    $display("undervoltage done");
    apb(1'b1, `PFS_CFG_OFS, 32'h0000_402A, rd, er);
    vtrack_mv <= 16'h02ED;
    repeat (300) @(posedge mclk);
    note(32'(stage_off_cmd), 32'h0);
    ramp_up <= 1'b1;
    wait_out(0, 1'b1, 400, n);
    note(32'(n inside {[DLO:DHI]}), 32'h1);
    ramp_up <= 1'b0;
    vtrack_mv <= 16'h03E8;
    apb(1'b1, `PFS_CFG_OFS, `PFS_CFG_RST, rd, er);
    wait_out(0, 1'b0, 2000, n);
    $display("tracking done");
    t_tgt <= 8'h7D;
    wait_out(2, 1'b1, 400, n);
    note(32'(n inside {[DLO:DHI]}), 32'h1);
    note(32'(stage_off_cmd), 32'h0);
    t_tgt <= 8'h82;
    wait_out(0, 1'b1, 400, n);
    note(32'(n inside {[DLO:DHI]}), 32'h1);
    t_tgt <= 8'h79;
    repeat (RCYC + 400) @(posedge mclk);
    note(32'(stage_off_cmd), 32'h1);
    note(32'(ot_warning), 32'h1);
    t_tgt <= 8'h78;
    wait_out(0, 1'b0, RCYC + 400, n);
    note(32'(ot_warning), 32'h1);
    t_tgt <= 8'h75;
    wait_out(2, 1'b0, 400, n);
    $display("temperature done");
    apb(1'b1, `PFS_CFG_OFS, 32'h0000_4155, rd, er);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    note(32'(stage_off_cmd), 32'h1);
    apb(1'b0, `PFS_CFG_OFS, 32'h0, rd, er);
    note(rd, `PFS_CFG_RST);
    $display("reset done");
    stop_test;
  end
endmodule : testbench
